// File: src/stc_pkg.sv
// package of constants and types for the sim translator control block
package stc_pkg;
  // ********************************************************
  // serial bus
  // ********************************************************
  localparam logic [6:0] STC_ADDR_VAR_A = 7'h60;
  localparam logic [6:0] STC_ADDR_VAR_B = 7'h61;
  localparam logic [6:0] STC_ADDR_VAR_C = 7'h62;
  localparam logic [7:0] STC_PTR_VALUE = 8'h00;
  localparam int STC_STD_KHZ = 100;
  localparam int STC_FAST_KHZ = 400;
  // ********************************************************
  // device_configuration register
  // ********************************************************
  localparam logic [7:0] STC_CFG_RESET = 8'h00;
  localparam int STC_BIT_REG_DIS = 7;
  localparam int STC_BIT_PIN_FN = 6;
  localparam int STC_BIT_RST_ACT = 5;
  localparam int STC_BIT_LATCH = 4;
  localparam int STC_BIT_EN_POL = 3;
  localparam int STC_BIT_VSEL = 1;
  localparam int STC_BIT_DEV_EN = 0;
  localparam logic [7:0] STC_CFG_WMASK = 8'hfb;
  // ********************************************************
  // timing
  // ********************************************************
  localparam int STC_CLK_MHZ = 200;
  localparam int STC_ONESHOT_NS = 20;
  localparam int STC_ONESHOT_CYC =
    (STC_ONESHOT_NS * STC_CLK_MHZ + 999) / 1000;
  localparam int STC_UPD_CYC = 4;
  localparam int STC_FILT_CYC = 2;
  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [2:0] {
    STC_IDLE, STC_ADDR, STC_AACK, STC_WDATA, STC_WACK,
    STC_RDATA, STC_RACK, STC_WAITP
  } stc_state_t;
  typedef enum logic [1:0] {
    STC_DIR_NONE, STC_DIR_HOST, STC_DIR_CARD
  } stc_dir_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } stc_bus_in_t;
  typedef struct packed {
    logic regulator_on;
    logic voltage_select;
    logic supply_pulldown;
  } stc_supply_t;
endpackage : stc_pkg

// File: src/stc_core.sv
// sim translator control: serial slave, config register and channels
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - first falling side owns data; other follows
// - one-shot drive helps rising data edge
// - both driving low releases both high
// - reset and clock go host to card only
// - supply defaults low, write selects level
// - translation stays active with regulator off
// - thermal or overcurrent fault disables regulator
// - pull-down card supply while regulator off
// - power-on reset sets register and machine
// - slave works at any clock to maximum
// - bytes move msb first, master clocks
// - address byte: seven bits plus direction
// - one fixed address chosen per variant
// - no subaddress; next byte is data
// - read ack or nack both accepted
// - slave acks address and write data
// - register updates only after stop
// - requests ignored during register update
// - bit 1 selects supply level
// - bit 7 disables regulator when set
// - bit 6 chooses reset or enable pin
// - bit 0 enables; read-only in pin mode
module stc_core #(
  parameter int VARIANT = 0
) (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic reset,
  // serial bus
  input wire stc_pkg::stc_bus_in_t bus_in,
  output logic sda_out,
  output logic sda_oe,
  // host side pins
  input wire logic host_data_in,
  output logic host_data_out,
  output logic host_data_oe,
  input wire logic host_clock_in,
  input wire logic host_reset_en,
  // card side pins
  input wire logic card_data_line_in,
  output logic card_data_line_out,
  output logic card_data_line_oe,
  output logic card_clock_out,
  output logic card_reset_out,
  // regulator
  input wire logic thermal_fault,
  input wire logic overcurrent_fault,
  output stc_pkg::stc_supply_t card_supply_output,
  output logic device_active,
  output logic [7:0] device_configuration
);
  import stc_pkg::*;

  // only three fixed addresses exist, so other variants are refused
  if (VARIANT < 0 || VARIANT > 2) begin : g_bad_variant
    $error("VARIANT must be 0, 1 or 2");
  end

  localparam logic [6:0] OWN_ADDR = (VARIANT == 0) ? STC_ADDR_VAR_A :
    (VARIANT == 1) ? STC_ADDR_VAR_B : STC_ADDR_VAR_C;

  // ********************************************************
  // serial bus sampling and start/stop detection
  // ********************************************************
  logic [1:0] scl_h_q;
  logic [1:0] sda_h_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_h_q <= 2'h3;
      sda_h_q <= 2'h3;
    end else begin
      scl_h_q <= {scl_h_q[0], bus_in.scl};
      sda_h_q <= {sda_h_q[0], bus_in.sda};
    end
  end
  wire scl_rise = scl_h_q == 2'h1;
  wire scl_fall = scl_h_q == 2'h2;
  wire bit_start = scl_h_q[0] && (sda_h_q == 2'h2);
  wire bit_stop = scl_h_q[0] && (sda_h_q == 2'h1);
  wire sda_s = sda_h_q[0];

  // ********************************************************
  // slave state machine
  // ********************************************************
  stc_state_t state_q;
  stc_state_t state_d;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] cfg_q;
  logic [7:0] pend_q;
  logic pend_ok_q;
  logic [2:0] upd_q;
  logic sda_oe_q;
  logic [7:0] read_view;
  wire busy = upd_q != 3'h0;
  wire byte_done = scl_rise && (bit_q == 4'h7);
  wire [7:0] shift_next = {shift_q[6:0], sda_s};
  wire addr_match = shift_next[7:1] == OWN_ADDR;
  wire read_first = shift_q[0] && !read_view[7];

  always_comb begin
    state_d = state_q;
    case (state_q)
      STC_IDLE: state_d = state_q;
      STC_ADDR: begin
        if (byte_done) begin
          state_d = addr_match ? STC_AACK : STC_WAITP;
        end
      end
      STC_AACK: begin
        if (scl_fall && sda_oe_q) begin
          state_d = shift_q[0] ? STC_RDATA : STC_WDATA;
        end
      end
      STC_WDATA: begin
        if (byte_done) begin
          state_d = STC_WACK;
        end
      end
      STC_WACK: begin
        if (scl_fall && sda_oe_q) begin
          state_d = STC_WAITP;
        end
      end
      STC_RDATA: begin
        if (scl_fall && bit_q == 4'h8) begin
          state_d = STC_RACK;
        end
      end
      STC_RACK: begin
        if (scl_fall) begin
          state_d = STC_WAITP;
        end
      end
      STC_WAITP: state_d = state_q;
      default: state_d = STC_IDLE;
    endcase
    if (bit_stop) begin
      state_d = STC_IDLE;
    end else if (bit_start) begin
      state_d = busy ? STC_WAITP : STC_ADDR;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= STC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || bit_start || state_d != state_q) begin
      bit_q <= 4'h0;
    end else if (scl_rise) begin
      bit_q <= bit_q + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_q <= 8'h00;
    end else if (scl_rise && (state_q == STC_ADDR ||
        state_q == STC_WDATA)) begin
      shift_q <= shift_next;
    end else if (state_q == STC_AACK && state_d == STC_RDATA) begin
      // msb goes out as the ack ends, so keep only the bits still to send
      shift_q <= {read_view[6:0], 1'b0};
    end else if (state_q == STC_RDATA && scl_fall) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end
  end

  // ack drive: asserted from the falling edge after bit 8 until the
  // falling edge after the ninth clock
  always_ff @(posedge mclk) begin
    if (reset || bit_start || bit_stop) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      case (state_q)
        STC_AACK: sda_oe_q <= sda_oe_q ? read_first : 1'b1;
        STC_WACK: sda_oe_q <= ~sda_oe_q;
        STC_RDATA: sda_oe_q <= (bit_q != 4'h8) && !shift_q[7];
        default: sda_oe_q <= 1'b0;
      endcase
    end
  end

  // ********************************************************
  // register write: captured at ack, committed after stop
  // ********************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_q <= STC_CFG_RESET;
      pend_ok_q <= 1'b0;
    end else if (state_q == STC_WACK && state_d == STC_WAITP) begin
      pend_q <= shift_q;
      pend_ok_q <= 1'b1;
    end else if (bit_start) begin
      pend_ok_q <= 1'b0;
    end else if (bit_stop) begin
      pend_ok_q <= 1'b0;
    end
  end

  // starts only after stop, so a half-sent byte never reaches the pins
  always_ff @(posedge mclk) begin
    if (reset) begin
      upd_q <= 3'h0;
    end else if (bit_stop && pend_ok_q) begin
      upd_q <= 3'(STC_UPD_CYC);
    end else if (busy) begin
      upd_q <= upd_q - 3'h1;
    end
  end

  wire pin_mode = cfg_q[STC_BIT_PIN_FN];
  wire pin_enable = host_reset_en ^ cfg_q[STC_BIT_EN_POL];
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_q <= STC_CFG_RESET;
    end else if (upd_q == 3'h1) begin
      cfg_q <= pend_q & STC_CFG_WMASK;
    end
  end
  // bit 0 reads the pin state while in pin enable mode
  assign read_view = pin_mode ?
    {cfg_q[7:1], pin_enable} : cfg_q;
  wire dev_en = pin_mode ? pin_enable : cfg_q[STC_BIT_DEV_EN];

  // ********************************************************
  // data channel direction logic
  // ********************************************************
  // only a fresh fall claims the line; a side already low when ownership
  // ends cannot seize it, which keeps a double drive from sticking
  stc_dir_t dir_q;
  logic host_prev_q;
  logic card_prev_q;
  logic [2:0] shot_q;
  logic shot_host_q;
  wire host_low = !host_data_in;
  wire card_low = !card_data_line_in;
  always_ff @(posedge mclk) begin
    if (reset || !dev_en) begin
      dir_q <= STC_DIR_NONE;
    end else begin
      case (dir_q)
        STC_DIR_NONE: begin
          if (host_low && host_prev_q) begin
            dir_q <= STC_DIR_HOST;
          end else if (card_low && card_prev_q) begin
            dir_q <= STC_DIR_CARD;
          end
        end
        STC_DIR_HOST: if (!host_low) dir_q <= STC_DIR_NONE;
        STC_DIR_CARD: if (!card_low) dir_q <= STC_DIR_NONE;
        default: dir_q <= STC_DIR_NONE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      host_prev_q <= 1'b1;
      card_prev_q <= 1'b1;
      shot_q <= 3'h0;
      shot_host_q <= 1'b0;
    end else begin
      host_prev_q <= host_data_in;
      card_prev_q <= card_data_line_in;
      if (dir_q == STC_DIR_HOST && !host_low) begin
        shot_q <= 3'(STC_ONESHOT_CYC);
        shot_host_q <= 1'b0;
      end else if (dir_q == STC_DIR_CARD && !card_low) begin
        shot_q <= 3'(STC_ONESHOT_CYC);
        shot_host_q <= 1'b1;
      end else if (shot_q != 3'h0) begin
        shot_q <= shot_q - 3'h1;
      end
    end
  end

  // ********************************************************
  // registered outputs
  // ********************************************************
  wire latched = cfg_q[STC_BIT_LATCH];
  wire vsel = cfg_q[STC_BIT_VSEL];
  wire reg_dis = cfg_q[STC_BIT_REG_DIS];
  wire reg_on = dev_en && !reg_dis &&
    !thermal_fault && !overcurrent_fault;
  wire shot_on = shot_q != 3'h0;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      host_data_out <= 1'b1;
      host_data_oe <= 1'b0;
      card_data_line_out <= 1'b1;
      card_data_line_oe <= 1'b0;
      card_clock_out <= 1'b0;
      card_reset_out <= 1'b0;
      card_supply_output <= '{1'b0, 1'b0, 1'b1};
      device_active <= 1'b0;
      device_configuration <= STC_CFG_RESET;
    end else begin
      sda_out <= 1'b0;
      sda_oe <= sda_oe_q;
      // translation ignores regulator bit; needs enable, and card side drive also needs latch bit clear
      host_data_out <= !(dir_q == STC_DIR_CARD);
      host_data_oe <= dev_en &&
        (dir_q == STC_DIR_CARD || (shot_on && shot_host_q));
      card_data_line_out <= !(dir_q == STC_DIR_HOST);
      card_data_line_oe <= dev_en && !latched &&
        (dir_q == STC_DIR_HOST || (shot_on && !shot_host_q));
      if (!dev_en) begin
        card_clock_out <= 1'b0;
        card_reset_out <= 1'b0;
      end else if (!latched) begin
        card_clock_out <= host_clock_in;
        card_reset_out <= pin_mode ? cfg_q[STC_BIT_RST_ACT] :
          host_reset_en;
      end
      card_supply_output <= '{reg_on, vsel,
        !reg_on};
      device_active <= dev_en;
      device_configuration <= read_view;
    end
  end
endmodule : stc_core

`default_nettype wire

// File: bench/stc_host_model.sv
// serial bus master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module stc_host_model #(
  parameter int Q = 130
) (
  // clock
  input wire logic mclk,
  // slave pull on data
  input wire logic sda_oe,
  // lines seen by the slave
  output stc_pkg::stc_bus_in_t bus_in
);
  import stc_pkg::*;
  logic scl_q = 1'b1;
  logic pull_q = 1'b0;
  // ****
  // bit and byte timing
  // ****
  // pulled-up lines: a released line reads high
  assign bus_in = {scl_q, !(pull_q || sda_oe)};
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // 4*q cycles a bit keeps scl under fast-mode rate
  task automatic put_bit(input logic b);
    pull_q <= !b;
    wt(Q);
    scl_q <= 1'b1;
    wt(2 * Q);
    scl_q <= 1'b0;
    wt(Q);
  endtask : put_bit
  task automatic get_bit(output logic b);
    pull_q <= 1'b0;
    wt(Q);
    scl_q <= 1'b1;
    wt(Q);
    b = bus_in.sda;
    wt(Q);
    scl_q <= 1'b0;
    wt(Q);
  endtask : get_bit
  // one address byte, one data byte, msb first; wdata[0] is the read ack
  task automatic xfer(input logic [6:0] addr, input logic rd,
    input logic [7:0] wdata, output logic [7:0] rdata,
    output logic ack_a, output logic ack_d);
    logic b;
    logic [7:0] sh;
    sh = {addr, rd};
    rdata = 8'h00;
    pull_q <= 1'b1;
    wt(Q);
    scl_q <= 1'b0;
    wt(Q);
    for (int i = 7; i >= 0; i--) put_bit(sh[i]);
    get_bit(b);
    ack_a = !b;
    for (int i = 7; i >= 0; i--) begin
      if (rd) get_bit(rdata[i]);
      else put_bit(wdata[i]);
    end
    if (rd) begin
      put_bit(!wdata[0]);
      ack_d = wdata[0];
    end else begin
      get_bit(b);
      ack_d = !b;
    end
    pull_q <= 1'b1;
    wt(Q);
    scl_q <= 1'b1;
    wt(Q);
    pull_q <= 1'b0;
    wt(2 * Q);
  endtask : xfer
endmodule : stc_host_model
`default_nettype wire

// File: bench/stc_core_asserts.sv
// concurrent checks on the ports of the sim translator control core
`timescale 1ns/10ps
`default_nettype none
module stc_core_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // serial bus
  input wire stc_pkg::stc_bus_in_t bus_in,
  input wire logic sda_oe,
  // channels
  input wire logic host_data_in,
  input wire logic host_data_out,
  input wire logic host_data_oe,
  input wire logic host_clock_in,
  input wire logic card_data_line_in,
  input wire logic card_data_line_oe,
  input wire logic card_data_line_out,
  input wire logic card_clock_out,
  input wire logic device_active,
  // regulator
  input wire logic thermal_fault,
  input wire logic overcurrent_fault,
  input wire stc_pkg::stc_supply_t card_supply_output,
  input wire logic [7:0] device_configuration
);
  import stc_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ****
  // properties
  // ****
  a_reset_defaults: assert property (
    $fell(reset) |-> device_configuration == STC_CFG_RESET && !sda_oe
    && card_supply_output == 3'b001) else $error("bad reset state");
  a_fault_off: assert property (
    (thermal_fault || overcurrent_fault) |-> ##[1:3]
    !card_supply_output.regulator_on) else $error("fault kept supply");
  a_pull_off: assert property (
    !card_supply_output.regulator_on |-> card_supply_output.supply_pulldown)
    else $error("supply left floating");
  a_vsel_follow: assert property (
    $rose(device_configuration[1]) |-> ##[0:2]
    card_supply_output.voltage_select) else $error("level not raised");
  a_clock_pass: assert property (
    device_active && !device_configuration[4] &&
    $past(!device_configuration[4]) && $past(!reset)
    |-> card_clock_out == $past(host_clock_in))
    else $error("card clock not following");
  a_sda_scl_low: assert property (
    $changed(sda_oe) |-> !bus_in.scl) else $error("sda moved, scl high");
  a_data_follow: assert property (
    device_active && $fell(card_data_line_in) && host_data_in &&
    !card_data_line_oe |-> ##[1:3] host_data_oe && !host_data_out)
    else $error("no follow");
  a_oneshot_rise: assert property (
    $rose(card_data_line_out) && card_data_line_oe |->
    (card_data_line_oe && card_data_line_out) [*3]) else $error("short");
endmodule : stc_core_asserts
bind stc_core stc_core_asserts stc_core_asserts_inst (.mclk, .reset,
  .bus_in, .sda_oe, .host_data_in, .host_data_out, .host_data_oe,
  .host_clock_in, .card_data_line_in, .card_data_line_oe,
  .card_data_line_out, .card_clock_out, .device_active, .thermal_fault,
  .overcurrent_fault, .card_supply_output, .device_configuration);
`default_nettype wire

// File: bench/sim_translator_i2c_control_test.sv
// self-checking bench for the sim translator control core
`timescale 1ns/10ps
`default_nettype none
module sim_translator_i2c_control_test;
  import stc_pkg::*;
  logic mclk, reset, h_low, c_low, host_clock_in, host_reset_en, aa, ad;
  logic thermal_fault, overcurrent_fault, sda_out, sda_oe, device_active;
  logic host_data_out, host_data_oe, card_clock_out, card_reset_out;
  logic card_data_line_out, card_data_line_oe;
  logic [7:0] device_configuration, rd;
  wire logic host_data_in, card_data_line_in;
  stc_bus_in_t bus_in;
  stc_supply_t card_supply_output;
  int n_mismatch = 0;
  int checked = 0;
  // both data pins are pulled up; either party may pull low
  assign host_data_in = !(h_low || (host_data_oe && !host_data_out));
  assign card_data_line_in =
    !(c_low || (card_data_line_oe && !card_data_line_out));
  stc_core #(.VARIANT(0)) stc_core_inst (.mclk, .reset, .bus_in, .sda_out,
    .sda_oe, .host_data_in, .host_data_out, .host_data_oe, .host_clock_in,
    .host_reset_en, .card_data_line_in, .card_data_line_out,
    .card_data_line_oe, .card_clock_out, .card_reset_out, .thermal_fault,
    .overcurrent_fault, .card_supply_output, .device_active,
    .device_configuration);
  stc_host_model stc_host_model_inst (.mclk, .sda_oe, .bus_in);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic xf(input logic [6:0] a, input logic r, input logic [7:0] d);
    stc_host_model_inst.xfer(a, r, d, rd, aa, ad);
  endtask : xf
  // ****
  // tests
  // ****
  initial begin
    repeat (100000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    {h_low, c_low, host_clock_in, host_reset_en} = 4'h0;
    {thermal_fault, overcurrent_fault} = 2'b00;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("cfg", device_configuration, STC_CFG_RESET);
    chk("supply", {5'h00, card_supply_output}, 8'h01);
    chk("idle", {6'h00, sda_out, device_active}, 8'h00);
    $display("reset test done");
    xf(STC_ADDR_VAR_A, 1'b0, 8'h03);
    chk("acks", {6'h00, aa, ad}, 8'h03);
    chk("cfg", device_configuration, 8'h03);
    chk("supply", {5'h00, card_supply_output}, 8'h06);
    chk("active", {7'h00, device_active}, 8'h01);
    // nack first, so the second read shows the slave recovered
    for (int i = 0; i < 2; i++) begin
      xf(STC_ADDR_VAR_A, 1'b1, 8'(i));
      chk("read ack", {7'h00, aa}, 8'h01);
      chk("read data", rd, 8'h03);
    end
    xf(STC_ADDR_VAR_B, 1'b0, 8'h80);
    chk("foreign ack", {7'h00, aa}, 8'h00);
    chk("cfg", device_configuration, 8'h03);
    $display("serial test done");
    for (int i = 0; i < 2; i++) begin
      thermal_fault <= (i == 0);
      overcurrent_fault <= (i == 1);
      repeat (4) @(posedge mclk);
      chk("fault", {7'h00, card_supply_output.regulator_on}, 8'h00);
      {thermal_fault, overcurrent_fault} <= 2'b00;
      repeat (4) @(posedge mclk);
      if (i == 0) h_low <= 1'b1;
      else c_low <= 1'b1;
      repeat (4) @(posedge mclk);
      chk("low", {6'h00, host_data_in, card_data_line_in}, 8'h00);
      {h_low, c_low} <= 2'b00;
      repeat (8) @(posedge mclk);
      chk("high", {6'h00, host_data_in, card_data_line_in}, 8'h03);
    end
    $display("channel test done");
    xf(STC_ADDR_VAR_A, 1'b0, 8'h83);
    chk("supply", {5'h00, card_supply_output}, 8'h03);
    {host_clock_in, host_reset_en} <= 2'b11;
    repeat (3) @(posedge mclk);
    chk("pass", {6'h00, card_clock_out, card_reset_out}, 8'h03);
    $display("regulator test done");
    // pin enable mode, active high, card reset taken from bit 5
    xf(STC_ADDR_VAR_A, 1'b0, 8'h62);
    chk("pin view", device_configuration, 8'h63);
    chk("pin on", {6'h00, card_clock_out, card_reset_out}, 8'h03);
    chk("pin act", {7'h00, device_active}, 8'h01);
    host_reset_en <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("pin off", {6'h00, card_clock_out, card_reset_out}, 8'h00);
    chk("pin act", {7'h00, device_active}, 8'h00);
    chk("pin view", device_configuration, 8'h62);
    $display("pin mode test done");
    // host drops its supply: the device starts over from defaults
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("cfg", device_configuration, STC_CFG_RESET);
    chk("supply", {5'h00, card_supply_output}, 8'h01);
    $display("power cycle test done");
    print_verdict();
  end
endmodule : sim_translator_i2c_control_test
`default_nettype wire
